// >>> common/aspi_pkg.sv
// Purpose: Constants and carriers for the audio serial port enable and interrupt block.
// Assumes: 16-bit register port, one module clock.
// Notes: Field positions follow the register layouts.
package aspi_pkg;
    localparam int unsigned DATA_W = 16;
    // Register select codes on the register port.
    localparam logic [0:0] SEL_GLOBAL_CONFIG = 1'h0;
    localparam logic [0:0] SEL_IRQ_SOURCE = 1'h1;
    // Global configuration register fields.
    localparam int unsigned GCR_ISDN_MODE = 13;
    localparam int unsigned GCR_MODULE_EN = 14;
    localparam int unsigned GCR_CLOCK_GATE = 15;
    localparam logic [15:0] GCR_RESET = 16'h0000;
    // Interrupt source register fields, low byte then clear strobes.
    localparam int unsigned ISR_RX_EN = 0;
    localparam int unsigned ISR_RXERR_EN = 1;
    localparam int unsigned ISR_TX_EN = 2;
    localparam int unsigned ISR_TXERR_EN = 3;
    localparam int unsigned ISR_RX_PEND = 4;
    localparam int unsigned ISR_RXERR_PEND = 5;
    localparam int unsigned ISR_TX_PEND = 6;
    localparam int unsigned ISR_TXERR_PEND = 7;
    localparam int unsigned ISR_RX_CLR = 8;
    localparam int unsigned ISR_RXERR_CLR = 9;
    localparam int unsigned ISR_TX_CLR = 10;
    localparam int unsigned ISR_TXERR_CLR = 11;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // Register port request: one access per cycle while valid.
    typedef struct packed {
        logic valid;
        logic write;
        logic [0:0] sel;
        logic [15:0] wdata;
    } aspi_req_t;

    // Four sources in order rx, rx error, tx, tx error (bit 0 upward).
    typedef struct packed {
        logic tx_err;
        logic tx;
        logic rx_err;
        logic rx;
    } aspi_src_t;

    typedef struct packed {
        logic isdn_link_mode_sel;
        logic audio_module_enable;
        logic module_clock_gate;
    } aspi_mode_t;
endpackage

// >>> logic/aspi_core.sv
// Purpose: Enable, clock gate, link mode and interrupt registers of the audio serial port.
// Assumes: Source flags arrive synchronous to i_clk from the datapath.
// Notes: Read data is registered and valid one cycle after a read request made while the clock gate is on.
//
// What this block does
// - Link mode bit one forces slave operation.
// - Link mode bit zero selects normal PCM mode.
// - Module enable bit, reset zero, gates module.
// - Clock gate resets zero; set before access.
// - Other config bits ignored while gate zero.
// - Source register selects single interrupt causes.
// - Enabled tx almost-empty raises tx interrupt.
// - Enabled tx underrun raises tx error interrupt.
// - Rx pending read-only, cleared by writing one.
// - Rx error pending cleared by writing one.
// - Tx pending cleared by writing one.
// - Tx error pending cleared by writing one.
// - Low byte: pendings high, enables low.
// - Rx enable zero blocks receive interrupts.
// - Enabled rx overrun raises rx error interrupt.
`timescale 1ns/1ns
module aspi_core #(
    parameter int unsigned DATA_WIDTH = 16,
    parameter int unsigned SRC_COUNT = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire aspi_pkg::aspi_req_t i_req,
    input wire aspi_pkg::aspi_src_t i_src,
    output aspi_pkg::aspi_mode_t o_mode,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic o_slave_only,
    output logic o_irq
);
    import aspi_pkg::*;

    // The field layout is fixed by the register map, so only these sizes can
    // be served; anything else is refused before it can misplace a field.
    if (DATA_WIDTH != DATA_W) begin : g_width_check
        $error("Register port width must be 16");
    end
    if (SRC_COUNT != 4) begin : g_count_check
        $error("Exactly four interrupt sources are supported");
    end

    // True for a write request aimed at one register.
    function automatic logic is_write_to(
        input aspi_req_t req,
        input logic [0:0] sel
    );
        is_write_to = req.valid && req.write && (req.sel == sel);
    endfunction

    // True for a read request to either register.
    function automatic logic is_read(input aspi_req_t req);
        is_read = req.valid && !req.write;
    endfunction

    // A config write without the gate bit leaves nothing set, which keeps the
    // other fields from being armed before the module clock runs.
    function automatic logic [15:0] gcr_after_write(input logic [15:0] wdata);
        if (wdata[GCR_CLOCK_GATE]) begin
            gcr_after_write = wdata;
        end else begin
            gcr_after_write = GCR_RESET;
        end
    endfunction

    // Read view of the source register; strobes and the top nibble read zero.
    function automatic logic [15:0] irq_view(
        input logic [3:0] pend,
        input logic [3:0] en
    );
        irq_view = 16'h0000;
        irq_view[ISR_TXERR_PEND:ISR_RX_PEND] = pend;
        irq_view[ISR_TXERR_EN:ISR_RX_EN] = en;
    endfunction

    // The module enable only counts while the module clock is on.
    function automatic aspi_mode_t mode_of(input logic [15:0] cfg);
        mode_of.isdn_link_mode_sel = cfg[GCR_ISDN_MODE];
        mode_of.audio_module_enable = cfg[GCR_MODULE_EN] & cfg[GCR_CLOCK_GATE];
        mode_of.module_clock_gate = cfg[GCR_CLOCK_GATE];
    endfunction

    logic rst_meta_b;
    logic rst_b;
    logic [15:0] gcr;
    logic [3:0] irq_en;
    logic pend_rx;
    logic pend_rxerr;
    logic pend_tx;
    logic pend_txerr;
    aspi_src_t src_q;

    // Reset is let go through two stages so every register leaves it together.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_b <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_b <= rst_meta_b;
        end
    end

    wire gate_on = gcr[GCR_CLOCK_GATE];
    // Register reads only work with the module clock running.
    wire access_ok = i_req.valid && gate_on;
    wire rd_ok = access_ok && is_read(i_req);
    // The gate bit itself is always writable, so a write that turns it on may
    // carry other bits too; with the gate off they are masked away.
    wire gate_in = is_write_to(i_req, SEL_GLOBAL_CONFIG);
    wire wr_isr = gate_on && is_write_to(i_req, SEL_IRQ_SOURCE);
    wire [15:0] next_gcr = gate_in ? gcr_after_write(i_req.wdata) : gcr;
    wire aspi_mode_t next_mode = mode_of(next_gcr);

    // Sources count on their rising edge: the flags stay set for a while.
    wire [3:0] src_rise = i_src & ~src_q;
    wire set_rx = src_rise[0] && irq_en[0];
    wire set_rxerr = src_rise[1] && irq_en[1];
    wire set_tx = src_rise[2] && irq_en[2];
    wire set_txerr = src_rise[3] && irq_en[3];
    wire [3:0] set = {set_txerr, set_tx, set_rxerr, set_rx};
    wire clr_rx = wr_isr && i_req.wdata[ISR_RX_CLR];
    wire clr_rxerr = wr_isr && i_req.wdata[ISR_RXERR_CLR];
    wire clr_tx = wr_isr && i_req.wdata[ISR_TX_CLR];
    wire clr_txerr = wr_isr && i_req.wdata[ISR_TXERR_CLR];
    wire [3:0] clr = {clr_txerr, clr_tx, clr_rxerr, clr_rx};
    wire [3:0] irq_pend = {pend_txerr, pend_tx, pend_rxerr, pend_rx};
    // A new event in the cycle of its clear wins over the clear.
    wire [3:0] next_pend = set | (irq_pend & ~clr);

    wire [15:0] next_rdata = (i_req.sel == SEL_GLOBAL_CONFIG) ? gcr
                             : irq_view(irq_pend, irq_en);

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            gcr <= GCR_RESET;
        end else begin
            gcr <= next_gcr;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_mode <= '0;
        end else begin
            o_mode <= next_mode;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_slave_only <= 1'b0;
        end else begin
            o_slave_only <= next_gcr[GCR_ISDN_MODE];
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_en <= IRQ_RESET;
        end else if (wr_isr) begin
            irq_en <= i_req.wdata[ISR_TXERR_EN:ISR_RX_EN];
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_rx <= IRQ_RESET[0];
        end else begin
            pend_rx <= next_pend[0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_rxerr <= IRQ_RESET[1];
        end else begin
            pend_rxerr <= next_pend[1];
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_tx <= IRQ_RESET[2];
        end else begin
            pend_tx <= next_pend[2];
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_txerr <= IRQ_RESET[3];
        end else begin
            pend_txerr <= next_pend[3];
        end
    end

    // Clearing to idle lets a source that is already high at release count
    // as a rising edge in the first cycle after it.
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            src_q <= '0;
        end else begin
            src_q <= i_src;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_rdata <= 16'h0000;
        end else if (rd_ok) begin
            o_rdata <= next_rdata;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= rd_ok;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |next_pend;
        end
    end
endmodule

// >>> bench/aspi_core_sva.sv
// Purpose: Port assertions for the audio port enable and interrupt block.
// Assumes: Bound onto the core; internal reset lags the port reset by two edges.
// Notes: Pending bits are judged through the request line only.
`timescale 1ns/1ns
module aspi_core_sva (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire aspi_pkg::aspi_req_t i_req,
    input wire aspi_pkg::aspi_src_t i_src,
    input wire aspi_pkg::aspi_mode_t o_mode,
    input wire logic [15:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_slave_only,
    input wire logic o_irq
);
    import aspi_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic rd = i_req.valid && !i_req.write;
    wire logic gate = o_mode.module_clock_gate;
    wire logic wr_isr = i_req.valid && i_req.write && i_req.sel == SEL_IRQ_SOURCE;
    wire logic wr_off = i_req.valid && i_req.write && i_req.sel == SEL_GLOBAL_CONFIG;
    property p_slave; o_slave_only == o_mode.isdn_link_mode_sel; endproperty
    a_slave: assert property (p_slave) else $error("slave flag off");
    property p_en; o_mode.audio_module_enable |-> gate; endproperty
    a_en: assert property (p_en) else $error("enable without gate");
    property p_rd; rd && gate |=> o_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_rv; o_rvalid |-> $past(rd && gate); endproperty
    a_rv: assert property (p_rv) else $error("stray read valid");
    property p_lock; !gate && wr_off && !i_req.wdata[15] |=> o_mode == 3'h0; endproperty
    a_lock: assert property (p_lock) else $error("config set while gated");
    property p_hi; o_rvalid && $past(i_req.sel) |-> o_rdata[15:8] == 8'h00; endproperty
    a_hi: assert property (p_hi) else $error("clear bits read back");
    property p_fall; $fell(o_irq) |-> $past(wr_isr && gate); endproperty
    a_fall: assert property (p_fall) else $error("request dropped alone");
    property p_rise; $rose(o_irq) |-> |($past(i_src) & ~$past(i_src, 2)); endproperty
    a_rise: assert property (p_rise) else $error("request without event");
    c_rd: cover property (o_rvalid);
    c_rise: cover property ($rose(o_irq));
    c_fall: cover property ($fell(o_irq));
endmodule

// >>> bench/aspi_src_model.sv
// Purpose: Datapath flag model feeding the four interrupt sources.
// Assumes: The bench holds a kick bit for one rising edge.
// Notes: Each kick gives a one-cycle level, so exactly one rising event.
`timescale 1ns/1ns
module aspi_src_model (
    input wire logic i_clk,
    input wire logic [3:0] i_kick,
    output aspi_pkg::aspi_src_t o_src
);
    import aspi_pkg::*;
    // Taken on the rising edge by non-blocking assignment, so the kick that the
    // bench writes at the falling edge never races this model.
    always @(posedge i_clk) o_src <= aspi_src_t'(i_kick);
endmodule

// >>> bench/test_audio_port_irq_and_enable.sv
// Purpose: Self-checking bench for the audio port enable and interrupt block.
// Assumes: Inputs change on the falling edge.
// Notes: Enables are random from a fixed seed.
`timescale 1ns/1ns
module test_audio_port_irq_and_enable;
    import aspi_pkg::*;
    logic i_clk = 1'h0, i_rst_b = 1'h0, o_rvalid, o_slave_only, o_irq;
    aspi_req_t i_req = '0;
    aspi_src_t i_src;
    aspi_mode_t o_mode;
    logic [15:0] o_rdata;
    logic [3:0] kick = 4'h0, en, p;
    int err_count = 0, check_count = 0, cyc = 0, seed = 32'hA930;
    wire logic [21:0] obs = {o_rvalid, o_irq, o_slave_only, o_mode, o_rdata};
    always #10 i_clk = ~i_clk;
    aspi_src_model src_u (.i_clk, .i_kick(kick), .o_src(i_src));
    aspi_core dut_u (.i_clk, .i_rst_b, .i_req, .i_src, .o_mode, .o_rdata, .o_rvalid,
        .o_slave_only, .o_irq);
    function automatic logic [21:0] want(input logic [3:0] pd, input logic [3:0] e);
        return {1'h1, |pd, 4'h1, 8'h00, pd, e};
    endfunction
    task automatic chk(input logic [21:0] got, input logic [21:0] exp_v);
        check_count++;
        if (got !== exp_v) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp_v);
        end
    endtask
    task automatic acc(input logic wr, input logic sel, input logic [15:0] wd);
        @(negedge i_clk);
        i_req = '{1'h1, wr, sel, wd};
        @(negedge i_clk);
        i_req.valid = 1'h0;
    endtask
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 3000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(negedge i_clk);
        i_rst_b = 1'h1;
        repeat (3) @(negedge i_clk);
        acc(1'h0, SEL_IRQ_SOURCE, 16'h0000);
        chk(obs, 22'h0);
        acc(1'h1, SEL_GLOBAL_CONFIG, 16'h6000);
        chk(obs, 22'h0);
        acc(1'h1, SEL_GLOBAL_CONFIG, 16'h8000);
        acc(1'h1, SEL_GLOBAL_CONFIG, 16'hE000);
        chk(obs[21:16], 6'h0F);
        acc(1'h1, SEL_GLOBAL_CONFIG, 16'h8000);
        chk(obs[21:16], 6'h01);
        for (int j = 0; j < 8; j++) begin
            en = 4'($random(seed));
            p = en & (4'h1 << j[1:0]);
            acc(1'h1, SEL_IRQ_SOURCE, {12'h000, en});
            @(negedge i_clk) kick = 4'h1 << j[1:0];
            @(negedge i_clk) kick = 4'h0;
            repeat (2) @(negedge i_clk);
            acc(1'h0, SEL_IRQ_SOURCE, 16'h0000);
            chk(obs, want(p, en));
            acc(1'h1, SEL_IRQ_SOURCE, {12'h000, en});
            acc(1'h0, SEL_IRQ_SOURCE, 16'h0000);
            chk(obs, want(p, en));
            acc(1'h1, SEL_IRQ_SOURCE, {4'h0, p, 4'h0, en});
            acc(1'h0, SEL_IRQ_SOURCE, 16'h0000);
            chk(obs, want(4'h0, en));
        end
        wrap_up();
    end
endmodule
bind aspi_core aspi_core_sva chk_u (.i_clk, .i_rst_b, .i_req, .i_src, .o_mode, .o_rdata,
    .o_rvalid, .o_slave_only, .o_irq);
